// file: include/pesd_params.svh
`ifndef PESD_PARAMS_SVH
`define PESD_PARAMS_SVH

// ---------------------------------------------
// event codes and unit masks
// ---------------------------------------------
`define PESD_EC_LOAD      8'hcb
`define PESD_EC_TRANS     8'hcc
`define PESD_EC_ASSIST    8'hcd
`define PESD_EC_VRET      8'hce
`define PESD_EC_VSAT      8'hcf
`define PESD_EC_STALL     8'hd2
`define PESD_UM_XMISS     8'h10
`define PESD_UM_NONE      8'h00
`define PESD_UM_TO_PINT   8'h01
`define PESD_UM_TO_FP     8'h02
`define PESD_UM_PORT      8'h01
`define PESD_UM_PARTIAL   8'h02
`define PESD_UM_FLAGS     8'h04
`define PESD_UM_STAT      8'h08
`define PESD_UM_ANY       8'h0f

// ---------------------------------------------
// weights and widths
// ---------------------------------------------
`define PESD_STAT_WEIGHT  2'h2
`define PESD_ONE          2'h1
`define PESD_FLAG_W       6
`define PESD_ADDR_W       32

`endif

// file: include/pesd_pkg.sv
`include "pesd_params.svh"
package pesd_pkg;

  // ---------------------------------------------
  // pipeline indications, one group per stage
  // ---------------------------------------------
  typedef struct packed {
    logic        valid;
    logic        is_load;
    logic        xlate_miss;
    logic        fault;
    logic        cacheable;
    logic        sw_prefetch;
    logic        is_vector;
    logic        is_saturating;
  } pesd_retire_t;

  typedef struct packed {
    logic        valid;
    logic        is_fp;
    logic        is_packed_int;
    logic        empty_state;
    logic        state_changed;
  } pesd_exec_t;

  typedef struct packed {
    logic                      port_stall;
    logic                      partial_reg;
    logic                      flag_other;
    logic                      stat_write;
    logic                      flag_valid;
    logic [`PESD_FLAG_W-1:0]   flag_wr;
    logic [`PESD_FLAG_W-1:0]   flag_rd;
  } pesd_rename_t;

  typedef enum logic [1:0] {
    PESD_CLS_NONE,
    PESD_CLS_FP,
    PESD_CLS_PINT
  } pesd_class_t;

endpackage

// file: tb/pesd_pipe_model.sv
`timescale 1ns/10ps
`default_nettype none
module pesd_pipe_model
  import pesd_pkg::*;
(
  // stimulus selection
  input  wire logic [4:0]  op,
  input  wire logic [31:0] addr,
  // pipeline indications
  output pesd_retire_t     retire,
  output logic [31:0]      retire_addr,
  output pesd_exec_t       exec,
  output pesd_rename_t     rename
);
  // ---------------------------------------------
  // one instruction or stall per cycle, by op
  // ---------------------------------------------
  // empty slots carry busy qualifier bits on purpose: the block must gate on valid
  always_comb begin
    retire          = pesd_retire_t'(8'h7f);
    exec            = pesd_exec_t'(5'h0f);
    rename          = '0;
    rename.flag_wr  = 6'h15;
    rename.flag_rd  = 6'h2a;
    case (op)
      5'h01: retire = pesd_retire_t'(8'he8);   // cacheable load, translation miss
      5'h02: retire = pesd_retire_t'(8'hf8);   // same, but faulting
      5'h03: retire = pesd_retire_t'(8'he0);   // uncacheable miss
      5'h04: retire = pesd_retire_t'(8'hec);   // prefetch miss
      5'h05: exec   = pesd_exec_t'(5'h18);     // float instruction
      5'h06: exec   = pesd_exec_t'(5'h14);     // packed-integer instruction
      5'h07: exec   = pesd_exec_t'(5'h13);     // state emptying, state changed
      5'h08: exec   = pesd_exec_t'(5'h12);     // state emptying, nothing changed
      5'h09: retire = pesd_retire_t'(8'h82);   // vector instruction
      5'h0a: retire = pesd_retire_t'(8'h83);   // saturating vector instruction
      5'h0b: rename.port_stall  = 1'b1;
      5'h0c: rename.partial_reg = 1'b1;
      5'h0d: rename.flag_other  = 1'b1;
      5'h0e: rename.stat_write  = 1'b1;
      5'h0f, 5'h10, 5'h11, 5'h12: begin
        rename.flag_valid = 1'b1;
        rename.flag_wr    = (op == 5'h0f) ? 6'h03 : ((op == 5'h12) ? 6'h3f : 6'h00);
        rename.flag_rd    = (op == 5'h10) ? 6'h04 : ((op == 5'h11) ? 6'h01 : 6'h00);
      end
      default: ;
    endcase
    // address is only meaningful with a valid retire slot
    retire_addr = retire.valid ? addr : ~addr;
  end
endmodule
`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "pesd_params.svh"
module tb_top
  import pesd_pkg::*;
;
  typedef struct packed {
    logic [7:0] ec;
    logic [7:0] um;
    logic [4:0] a;
    logic [4:0] b;
    logic [1:0] ea;
    logic [1:0] eb;
    logic       sv;
  } pesd_row_t;

  logic          clk;
  logic          reset_n;
  logic [7:0]    evt_code;
  logic [7:0]    unit_mask;
  logic [4:0]    op;
  logic [31:0]   addr;
  pesd_retire_t  retire;
  logic [31:0]   retire_addr;
  pesd_exec_t    exec;
  pesd_rename_t  rename;
  logic          sel_valid;
  logic [1:0]    evt_inc;
  logic          sample_valid;
  logic [31:0]   sample_addr;
  int            n_errors;
  int            cmp_count;
  pesd_row_t     rows [23];

  pesd_pipe_model pipe (.op(op), .addr(addr), .retire(retire), .retire_addr(retire_addr),
                        .exec(exec), .rename(rename));

  pesd_top #(.ADDR_W(32)) uut (
    .clk(clk), .reset_n(reset_n), .evt_code(evt_code), .unit_mask(unit_mask),
    .retire(retire), .retire_addr(retire_addr), .exec(exec), .rename(rename),
    .sel_valid(sel_valid), .evt_inc(evt_inc), .sample_valid(sample_valid),
    .sample_addr(sample_addr));

  // ---------------------------------------------
  // clock, helpers
  // ---------------------------------------------
  always #12.5 clk = ~clk;

  task automatic tick;
    @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_done;
    $display("comparisons=%0d mismatches=%0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // about 90 cycles of tests; a hang is cut off well beyond that
  initial begin
    #(25 * 2000);
    n_errors++;
    test_done;
  end

  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial begin
    clk       = 1'b0;
    reset_n   = 1'b0;
    evt_code  = 8'h00;
    unit_mask = 8'h00;
    op        = 5'h00;
    addr      = 32'h0;
    n_errors  = 0;
    cmp_count = 0;
    rows = '{
      '{`PESD_EC_LOAD, `PESD_UM_XMISS, 5'h01, 5'h09, 2'h1, 2'h0, 1'b1},
      '{`PESD_EC_LOAD, `PESD_UM_XMISS, 5'h02, 5'h03, 2'h0, 2'h0, 1'b1},
      '{`PESD_EC_LOAD, `PESD_UM_XMISS, 5'h04, 5'h01, 2'h0, 2'h1, 1'b1},
      '{`PESD_EC_LOAD, 8'h01, 5'h01, 5'h01, 2'h0, 2'h0, 1'b0},
      '{`PESD_EC_TRANS, `PESD_UM_TO_PINT, 5'h05, 5'h06, 2'h0, 2'h1, 1'b1},
      '{`PESD_EC_TRANS, `PESD_UM_TO_PINT, 5'h06, 5'h06, 2'h0, 2'h0, 1'b1},
      '{`PESD_EC_TRANS, `PESD_UM_TO_FP, 5'h05, 5'h05, 2'h1, 2'h0, 1'b1},
      '{`PESD_EC_TRANS, `PESD_UM_TO_FP, 5'h06, 5'h05, 2'h0, 2'h1, 1'b1},
      '{`PESD_EC_ASSIST, `PESD_UM_NONE, 5'h07, 5'h08, 2'h1, 2'h0, 1'b1},
      '{`PESD_EC_ASSIST, 8'h01, 5'h07, 5'h07, 2'h0, 2'h0, 1'b0},
      '{`PESD_EC_VRET, `PESD_UM_NONE, 5'h09, 5'h0a, 2'h1, 2'h1, 1'b1},
      '{`PESD_EC_VSAT, `PESD_UM_NONE, 5'h09, 5'h0a, 2'h0, 2'h1, 1'b1},
      '{`PESD_EC_STALL, `PESD_UM_PORT, 5'h0b, 5'h0b, 2'h1, 2'h1, 1'b1},
      '{`PESD_EC_STALL, `PESD_UM_PARTIAL, 5'h0c, 5'h0b, 2'h1, 2'h0, 1'b1},
      '{`PESD_EC_STALL, `PESD_UM_FLAGS, 5'h0d, 5'h0c, 2'h1, 2'h0, 1'b1},
      '{`PESD_EC_STALL, `PESD_UM_FLAGS, 5'h0f, 5'h10, 2'h0, 2'h1, 1'b1},
      '{`PESD_EC_STALL, `PESD_UM_FLAGS, 5'h0f, 5'h11, 2'h0, 2'h0, 1'b1},
      '{`PESD_EC_STALL, `PESD_UM_FLAGS, 5'h12, 5'h10, 2'h0, 2'h0, 1'b1},
      '{`PESD_EC_STALL, `PESD_UM_STAT, 5'h0e, 5'h0b, 2'h2, 2'h0, 1'b1},
      '{`PESD_EC_STALL, `PESD_UM_ANY, 5'h0e, 5'h0c, 2'h1, 2'h1, 1'b1},
      '{`PESD_EC_STALL, `PESD_UM_ANY, 5'h0f, 5'h10, 2'h0, 2'h1, 1'b1},
      '{`PESD_EC_STALL, 8'h03, 5'h0b, 5'h0d, 2'h0, 2'h0, 1'b0},
      '{8'hd3, `PESD_UM_PORT, 5'h0b, 5'h0b, 2'h0, 2'h0, 1'b0}
    };
    // outputs stay quiet while reset is held
    repeat (3) tick;
    chk(32'(evt_inc), 32'h0);
    chk(32'(sel_valid), 32'h0);
    chk(32'(sample_valid), 32'h0);
    reset_n = 1'b1;
    repeat (4) tick;
    // table of two-instruction cases, one idle cycle between rows
    foreach (rows[i]) begin
      evt_code  = rows[i].ec;
      unit_mask = rows[i].um;
      op        = rows[i].a;
      tick;
      chk(32'(evt_inc), 32'(rows[i].ea));     // to
      chk(32'(sel_valid), 32'(rows[i].sv));
      op = rows[i].b;
      tick;
      chk(32'(evt_inc), 32'(rows[i].eb));     // to
      op = 5'h00;
      tick;
    end
    // precise sample: the miss's own address is skipped, an empty slot too
    evt_code  = `PESD_EC_LOAD;
    unit_mask = `PESD_UM_XMISS;
    op        = 5'h01;
    addr      = 32'h0000_1000;
    tick;
    op   = 5'h00;
    addr = 32'h0000_1800;
    chk(32'(evt_inc), 32'h1);
    chk(32'(sample_valid), 32'h0);
    tick;
    chk(32'(sample_valid), 32'h0);
    op   = 5'h09;
    addr = 32'h0000_2004;
    tick;
    // the sample pulse lands at the edge that takes the next retirement
    op = 5'h00;
    chk(32'(evt_inc), 32'h0);
    chk(32'(sample_valid), 32'h1);
    chk(sample_addr, 32'h0000_2004);
    tick;
    chk(32'(sample_valid), 32'h0);
    chk(sample_addr, 32'h0000_2004);
    // reset in mid-run, with a stall standing throughout
    evt_code  = `PESD_EC_STALL;
    unit_mask = `PESD_UM_PORT;
    op        = 5'h0b;
    tick;
    reset_n = 1'b0;
    tick;
    chk(32'(evt_inc), 32'h0);
    chk(32'(sel_valid), 32'h0);
    tick;
    reset_n = 1'b1;
    op      = 5'h00;
    repeat (4) tick;
    op = 5'h0b;
    tick;
    op = 5'h00;
    chk(32'(evt_inc), 32'h1);
    tick;
    test_done;
  end
endmodule
`default_nettype wire

// file: verilog/pesd_flag_watch.sv
`timescale 1ns/10ps
`default_nettype none
`include "pesd_params.svh"
module pesd_flag_watch
  import pesd_pkg::*;
#(
  parameter int FLAG_W = `PESD_FLAG_W
)(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // one flag-touching instruction per valid cycle
  input  wire logic              fl_valid,
  input  wire logic [FLAG_W-1:0] fl_wr,
  input  wire logic [FLAG_W-1:0] fl_rd,
  // partial flag hazard on the reader
  output logic                   partial
);

  // ---------------------------------------------
  // write mask of the previous flag-touching instruction, zero if it wrote none
  // ---------------------------------------------
  logic [FLAG_W-1:0] wr_q;
  logic [FLAG_W-1:0] wr_d;
  logic              part_wr;

  always_comb begin
    wr_d    = wr_q;
    part_wr = (wr_q != '0) && (wr_q != '1);
    partial = 1'b0;
    if (fl_valid) begin
      // reader needs flags the partial writer left alone
      partial = part_wr && ((fl_rd & ~wr_q) != '0);
      wr_d    = fl_wr;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
    end else begin
      wr_q <= wr_d;
    end
  end

endmodule
`default_nettype wire

// file: verilog/pesd_mode_track.sv
`timescale 1ns/10ps
`default_nettype none
module pesd_mode_track
  import pesd_pkg::*;
(
  // clock and reset
  input  wire logic  clk,
  input  wire logic  rst_n,
  // execution stream
  input  wire logic  ex_valid,
  input  wire logic  ex_fp,
  input  wire logic  ex_pint,
  // transitions, same cycle as the instruction
  output logic       to_pint,
  output logic       to_fp
);

  // ---------------------------------------------
  // last instruction class
  // ---------------------------------------------
  pesd_class_t last_q;
  pesd_class_t last_d;

  // one class per instruction; float wins if both flags stand
  always_comb begin
    last_d  = last_q;
    to_pint = 1'b0;
    to_fp   = 1'b0;
    if (ex_valid && ex_fp) begin
      to_fp  = (last_q == PESD_CLS_PINT);
      last_d = PESD_CLS_FP;
    end else if (ex_valid && ex_pint) begin
      to_pint = (last_q == PESD_CLS_FP);
      last_d  = PESD_CLS_PINT;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last_q <= PESD_CLS_NONE;
    end else begin
      last_q <= last_d;
    end
  end

endmodule
`default_nettype wire

// file: verilog/pesd_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "pesd_params.svh"
module pesd_top
  import pesd_pkg::*;
#(
  parameter int ADDR_W = `PESD_ADDR_W
)(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  // event selection
  input  wire logic [7:0]        evt_code,
  input  wire logic [7:0]        unit_mask,
  // pipeline indications
  input  wire pesd_retire_t      retire,
  input  wire logic [ADDR_W-1:0] retire_addr,
  input  wire pesd_exec_t        exec,
  input  wire pesd_rename_t      rename,
  // increment and precise sample
  output logic                   sel_valid,
  output logic [1:0]             evt_inc,
  output logic                   sample_valid,
  output logic [ADDR_W-1:0]      sample_addr
);

  // ---------------------------------------------
  // reset release
  // ---------------------------------------------
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // ---------------------------------------------
  // selection decode
  // ---------------------------------------------
  function automatic logic sel_is(input logic [7:0] ec,
                                  input logic [7:0] um,
                                  input logic [7:0] want_ec,
                                  input logic [7:0] want_um);
    sel_is = (ec == want_ec) && (um == want_um);
  endfunction

  logic s_xmiss;
  logic s_to_pint;
  logic s_to_fp;
  logic s_assist;
  logic s_vret;
  logic s_vsat;
  logic s_port;
  logic s_part;
  logic s_flag;
  logic s_stat;
  logic s_any;
  logic s_listed;

  // exact pairs only; unlisted pairs never count
  always_comb begin
    s_xmiss   = sel_is(evt_code, unit_mask, `PESD_EC_LOAD, `PESD_UM_XMISS);
    s_to_pint = sel_is(evt_code, unit_mask, `PESD_EC_TRANS, `PESD_UM_TO_PINT);
    s_to_fp   = sel_is(evt_code, unit_mask, `PESD_EC_TRANS, `PESD_UM_TO_FP);
    s_assist  = sel_is(evt_code, unit_mask, `PESD_EC_ASSIST, `PESD_UM_NONE);
    s_vret    = sel_is(evt_code, unit_mask, `PESD_EC_VRET, `PESD_UM_NONE);
    s_vsat    = sel_is(evt_code, unit_mask, `PESD_EC_VSAT, `PESD_UM_NONE);
    s_port    = sel_is(evt_code, unit_mask, `PESD_EC_STALL, `PESD_UM_PORT);
    s_part    = sel_is(evt_code, unit_mask, `PESD_EC_STALL, `PESD_UM_PARTIAL);
    s_flag    = sel_is(evt_code, unit_mask, `PESD_EC_STALL, `PESD_UM_FLAGS);
    s_stat    = sel_is(evt_code, unit_mask, `PESD_EC_STALL, `PESD_UM_STAT);
    s_any     = sel_is(evt_code, unit_mask, `PESD_EC_STALL, `PESD_UM_ANY);
    s_listed  = s_xmiss | s_to_pint | s_to_fp | s_assist | s_vret | s_vsat |
                s_port | s_part | s_flag | s_stat | s_any;
  end

  // ---------------------------------------------
  // raw conditions
  // ---------------------------------------------
  logic to_pint;
  logic to_fp;
  logic part_flag;
  logic c_xmiss;
  logic c_assist;
  logic c_vret;
  logic c_vsat;
  logic c_flag;
  logic c_any;

  pesd_mode_track u_mode (
    .clk      (clk),
    .rst_n    (rst_n_q),
    .ex_valid (exec.valid),
    .ex_fp    (exec.is_fp),
    .ex_pint  (exec.is_packed_int),
    .to_pint  (to_pint),
    .to_fp    (to_fp)
  );

  pesd_flag_watch #(
    .FLAG_W (`PESD_FLAG_W)
  ) u_flag (
    .clk      (clk),
    .rst_n    (rst_n_q),
    .fl_valid (rename.flag_valid),
    .fl_wr    (rename.flag_wr),
    .fl_rd    (rename.flag_rd),
    .partial  (part_flag)
  );

  always_comb begin
    c_xmiss  = retire.valid && retire.is_load && retire.xlate_miss &&
               !retire.fault &&
               retire.cacheable && !retire.sw_prefetch;
    c_assist = exec.valid && exec.empty_state && exec.state_changed;
    c_vret   = retire.valid && retire.is_vector;
    c_vsat   = c_vret && retire.is_saturating;
    c_flag   = rename.flag_other || part_flag;
    // a status word write is a stall cycle for the combined case too
    c_any    = rename.port_stall || rename.partial_reg || c_flag ||
               rename.stat_write;
  end

  // ---------------------------------------------
  // increment amount
  // ---------------------------------------------
  logic [1:0] inc_d;
  logic [1:0] inc_q;
  logic       sel_d;
  logic       sel_q;

  always_comb begin
    inc_d = 2'h0;
    sel_d = s_listed;
    if (s_xmiss && c_xmiss) begin
      inc_d = `PESD_ONE;
    end
    if (s_to_pint && to_pint) begin
      inc_d = `PESD_ONE;
    end
    if (s_to_fp && to_fp) begin
      inc_d = `PESD_ONE;
    end
    if (s_assist && c_assist) begin
      inc_d = `PESD_ONE;
    end
    if (s_vret && c_vret) begin
      inc_d = `PESD_ONE;
    end
    if (s_vsat && c_vsat) begin
      inc_d = `PESD_ONE;
    end
    // a level per cycle, so a retried entry counts again
    if (s_port && rename.port_stall) begin
      inc_d = `PESD_ONE;
    end
    if (s_part && rename.partial_reg) begin
      inc_d = `PESD_ONE;
    end
    if (s_flag && c_flag) begin
      inc_d = `PESD_ONE;
    end
    if (s_stat && rename.stat_write) begin
      inc_d = `PESD_STAT_WEIGHT;
    end
    if (s_any && c_any) begin
      inc_d = `PESD_ONE;
    end
  end

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      inc_q <= 2'h0;
      sel_q <= 1'b0;
    end else begin
      inc_q <= inc_d;
      sel_q <= sel_d;
    end
  end

  assign evt_inc   = inc_q;
  assign sel_valid = sel_q;

  // ---------------------------------------------
  // precise sample of the next retired address
  // ---------------------------------------------
  logic              pend_q;
  logic              pend_d;
  logic              smp_v_q;
  logic              smp_v_d;
  logic [ADDR_W-1:0] smp_a_q;
  logic [ADDR_W-1:0] smp_a_d;
  logic              hit;

  // the causing load retires in the hit cycle; only a later
  // retirement is the instruction after it
  always_comb begin
    hit     = s_xmiss && c_xmiss;
    pend_d  = pend_q;
    smp_v_d = 1'b0;
    smp_a_d = smp_a_q;
    if (pend_q && retire.valid) begin
      smp_v_d = 1'b1;
      smp_a_d = retire_addr;
      pend_d  = 1'b0;
    end
    if (hit) begin
      pend_d = 1'b1;
    end
    if (!s_xmiss) begin
      pend_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pend_q  <= 1'b0;
      smp_v_q <= 1'b0;
      smp_a_q <= '0;
    end else begin
      pend_q  <= pend_d;
      smp_v_q <= smp_v_d;
      smp_a_q <= smp_a_d;
    end
  end

  assign sample_valid = smp_v_q;
  assign sample_addr  = smp_a_q;

  // ---------------------------------------------
  // checks
  // ---------------------------------------------
  a_xmiss_count: assert property (@(posedge clk) disable iff (!rst_n_q)
    s_xmiss && retire.valid && retire.is_load && retire.xlate_miss &&
    retire.cacheable && !retire.sw_prefetch && !retire.fault
    |=> evt_inc == 2'h1)
    else $error("retired load miss not counted");

  a_fault_blocks: assert property (@(posedge clk) disable iff (!rst_n_q)
    s_xmiss && retire.fault |=> evt_inc == 2'h0)
    else $error("faulting load counted");

  a_prefetch_blocks: assert property (@(posedge clk) disable iff (!rst_n_q)
    s_xmiss && (retire.sw_prefetch || !retire.cacheable)
    |=> evt_inc == 2'h0)
    else $error("prefetch or uncached load counted");

  a_sample_next: assert property (@(posedge clk) disable iff (!rst_n_q)
    s_xmiss && c_xmiss ##1 (s_xmiss && retire.valid)
    |=> sample_valid && sample_addr == $past(retire_addr))
    else $error("precise sample address wrong");

  a_sample_cause: assert property (@(posedge clk) disable iff (!rst_n_q)
    $rose(sample_valid) |-> $past(pend_q))
    else $error("sample without a pending event");

  a_to_pint: assert property (@(posedge clk) disable iff (!rst_n_q)
    s_to_pint && exec.valid && exec.is_fp ##1
    s_to_pint && exec.valid && exec.is_packed_int && !exec.is_fp
    |=> evt_inc == 2'h1)
    else $error("float to packed transition missed");

  // both class flags set means float, so the first one must be pure packed
  a_pint_repeat: assert property (@(posedge clk) disable iff (!rst_n_q)
    s_to_pint && exec.valid && exec.is_packed_int && !exec.is_fp ##1
    s_to_pint && exec.valid && exec.is_packed_int
    |=> evt_inc == 2'h0)
    else $error("repeated packed instruction counted");

  a_to_fp: assert property (@(posedge clk) disable iff (!rst_n_q)
    s_to_fp && exec.valid && exec.is_packed_int && !exec.is_fp ##1
    s_to_fp && exec.valid && exec.is_fp
    |=> evt_inc == 2'h1)
    else $error("packed to float transition missed");

  a_assist_count: assert property (@(posedge clk) disable iff (!rst_n_q)
    s_assist |=> evt_inc == {1'b0, $past(exec.valid && exec.empty_state && exec.state_changed)})
    else $error("vector assist count wrong");

  a_vec_retired: assert property (@(posedge clk) disable iff (!rst_n_q)
    s_vret |=> evt_inc == {1'b0, $past(retire.valid && retire.is_vector)})
    else $error("vector retire count wrong");

  a_vec_sat: assert property (@(posedge clk) disable iff (!rst_n_q)
    s_vsat && retire.valid && retire.is_vector && !retire.is_saturating
    |=> evt_inc == 2'h0)
    else $error("plain vector counted as saturating");

  // evt_inc lags one cycle: the two stall cycles show at the last one and the next
  a_port_retry: assert property (@(posedge clk) disable iff (!rst_n_q)
    (s_port && rename.port_stall) [*2] |-> evt_inc == 2'h1 ##1 evt_inc == 2'h1)
    else $error("retried stall cycle not counted");

  a_port_level: assert property (@(posedge clk) disable iff (!rst_n_q)
    s_port |=> evt_inc == {1'b0, $past(rename.port_stall)})
    else $error("read port stall count wrong");

  a_partial_reg: assert property (@(posedge clk) disable iff (!rst_n_q)
    s_part |=> evt_inc == {1'b0, $past(rename.partial_reg)})
    else $error("partial register count wrong");

  a_flag_partial: assert property (@(posedge clk) disable iff (!rst_n_q)
    s_flag && part_flag |=> evt_inc == 2'h1)
    else $error("partial flag stall not counted");

  a_flag_detect: assert property (@(posedge clk) disable iff (!rst_n_q)
    rename.flag_valid && rename.flag_wr == 6'h03 ##1
    rename.flag_valid && rename.flag_rd == 6'h04 |-> part_flag)
    else $error("partial flag hazard missed");

  a_stat_double: assert property (@(posedge clk) disable iff (!rst_n_q)
    s_stat && rename.stat_write |=> evt_inc == 2'h2)
    else $error("status word write not doubled");

  a_any_union: assert property (@(posedge clk) disable iff (!rst_n_q)
    s_any |=> evt_inc == {1'b0, $past(rename.port_stall || rename.partial_reg ||
      rename.flag_other || part_flag || rename.stat_write)})
    else $error("combined stall count wrong");

  a_unlisted_quiet: assert property (@(posedge clk) disable iff (!rst_n_q)
    !s_listed |=> evt_inc == 2'h0 && !sel_valid)
    else $error("unlisted selection counted");

endmodule
`default_nettype wire
